/* File: design/pin_mux_defs.vh */
// constants for the pin function mux
`ifndef PIN_MUX_DEFS_VH
`define PIN_MUX_DEFS_VH
`define ADDR_W 4
`define DATA_W 8
`define REG_CTRL 4'h0
`define REG_DIR 4'h1
`define REG_PULL 4'h2
`define REG_OUT 4'h3
`define REG_IN 4'h4
`define REG_STAT 4'h5
`define REG_MASK 4'h6
`define REG_ALT 4'h7
`define CTRL_EN 0
`define CTRL_SYNC_EN 1
`define CTRL_SYNC_LINE 2
`define CTRL_PWM_EN 3
`define CTRL_DBG_EN 4
`define CTRL_PWM_DIV_LSB 5
`define CTRL_RST 8'h00
`define DIR_RST 8'h00
`define PULL_RST 8'h00
`define OUT_RST 8'h00
`define PWM_W 8
`define PWM_PERIOD 8'hFF
`define PWM_DUTY_RST 8'h80
`define FN_GP 2'h0
`define FN_SYNC 2'h1
`define FN_PWM 2'h2
`define FN_DBG 2'h3
`endif

/* File: design/pin_sync3.v */
// three flip-flop input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 (
  input wire clk_sys,
  input wire rst_b,
  input wire d,
  output reg q
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end
endmodule
`default_nettype wire

/* File: design/touch_ctrl_pin_function_mux.v */
// pin function selection for three general pins, sync input and attention line
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "pin_mux_defs.vh"
// How it works
// - three general pins, each set as input or output by configuration
// - after reset every general pin is an input
// - per-pin pull-up enable holds an unused input high
// - configuration disabled: no general pin use, alternative functions still work
// - an active alternative function owns its pin over general use
// - general pin zero unavailable while display sync is enabled
// - general pin one may carry PWM, set up in the same configuration
// - debug clock shares general pin one, blocking general use
// - debug data shares general pin two, blocking general use
// - sync input serves frame or line sync, never both
// - attention line low while response ready or message pending
// - each multi-function pin carries exactly one function at a time
module touch_ctrl_pin_function_mux (
  input wire clk_sys,
  input wire rst_b,
  input wire [`ADDR_W-1:0] addr,
  input wire [`DATA_W-1:0] wdata,
  input wire wr,
  input wire rd,
  output reg [`DATA_W-1:0] rdata,
  input wire [2:0] general_pin_in,
  output wire [2:0] general_pin_out,
  output wire [2:0] general_pin_oe,
  output wire [2:0] general_pin_pullup,
  input wire debug_active,
  output wire debug_clock_line,
  input wire debug_data_out,
  input wire debug_data_oe,
  output wire debug_data_line,
  output reg frame_sync,
  output reg line_sync,
  input wire response_ready,
  input wire message_pending,
  output wire host_attention_line_out,
  output wire host_attention_line_oe,
  output wire irq
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg [`DATA_W-1:0] ctrl;
  reg [2:0] dir;
  reg [2:0] pull;
  reg [2:0] outv;
  reg [3:0] stat;
  reg [3:0] mask;
  reg [`PWM_W-1:0] pwm_cnt;
  reg [`PWM_W-1:0] pwm_duty;
  reg pwm_state;
  reg pwm_q;
  reg [2:0] in_prev;
  wire [2:0] in_s;
  wire [1:0] fn0;
  wire [1:0] fn1;
  wire [1:0] fn2;
  wire [2:0] gp_ok;
  wire [2:0] edge_ev;
  wire alt_conflict;
  wire gen_en;

  // one function per pin, alternative functions first
  function [1:0] pick_fn;
    input alt_a;
    input [1:0] code_a;
    input alt_b;
    input [1:0] code_b;
    begin
      if (alt_a) begin
        pick_fn = code_a;
      end else if (alt_b) begin
        pick_fn = code_b;
      end else begin
        pick_fn = `FN_GP;
      end
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      pin_sync3 u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .d(general_pin_in[g]),
        .q(in_s[g])
      );
    end
  endgenerate

  assign gen_en = ctrl[`CTRL_EN];
  assign fn0 = pick_fn(ctrl[`CTRL_SYNC_EN], `FN_SYNC, 1'b0, `FN_GP);
  assign fn1 = pick_fn(debug_active | ctrl[`CTRL_DBG_EN], `FN_DBG, ctrl[`CTRL_PWM_EN], `FN_PWM);
  assign fn2 = pick_fn(debug_active | ctrl[`CTRL_DBG_EN], `FN_DBG, 1'b0, `FN_GP);
  assign gp_ok = {fn2 == `FN_GP, fn1 == `FN_GP, fn0 == `FN_GP} & {3{gen_en}};
  assign alt_conflict = ctrl[`CTRL_PWM_EN] & (debug_active | ctrl[`CTRL_DBG_EN]);

  // pin zero: sync input, or general pin
  assign general_pin_oe[0] = gp_ok[0] & dir[0];
  assign general_pin_out[0] = gp_ok[0] & outv[0];
  // pin one: debug clock input, pwm output, or general pin
  assign general_pin_oe[1] = (fn1 == `FN_PWM) | (gp_ok[1] & dir[1]);
  assign general_pin_out[1] = (fn1 == `FN_PWM) ? pwm_q : (gp_ok[1] & outv[1]);
  // pin two: debug data bidir, or general pin
  assign general_pin_oe[2] = (fn2 == `FN_DBG) ? debug_data_oe : (gp_ok[2] & dir[2]);
  assign general_pin_out[2] = (fn2 == `FN_DBG) ? (debug_data_oe & debug_data_out) : (gp_ok[2] & outv[2]);
  assign general_pin_pullup = pull & gp_ok & ~dir;
  assign debug_clock_line = (fn1 == `FN_DBG) & in_s[1];
  assign debug_data_line = (fn2 == `FN_DBG) & in_s[2];

  assign host_attention_line_out = 1'b0;
  assign host_attention_line_oe = response_ready | message_pending;

  assign edge_ev = (in_s ^ in_prev) & gp_ok & ~dir;
  assign irq = |(stat & mask);

  // sync input routed to one of two sync outputs only
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      frame_sync <= 1'b0;
      line_sync <= 1'b0;
    end else begin
      frame_sync <= ctrl[`CTRL_SYNC_EN] & ~ctrl[`CTRL_SYNC_LINE] & in_s[0];
      line_sync <= ctrl[`CTRL_SYNC_EN] & ctrl[`CTRL_SYNC_LINE] & in_s[0];
    end
  end

  // pwm generator on pin one
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pwm_state <= ST_IDLE;
      pwm_cnt <= {`PWM_W{1'b0}};
      pwm_q <= 1'b0;
    end else begin
      case (pwm_state)
        ST_IDLE: begin
          pwm_cnt <= {`PWM_W{1'b0}};
          pwm_q <= 1'b0;
          if (fn1 == `FN_PWM) begin
            pwm_state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (fn1 != `FN_PWM) begin
            pwm_state <= ST_IDLE;
            pwm_q <= 1'b0;
          end else begin
            if (pwm_cnt == `PWM_PERIOD) begin
              pwm_cnt <= {`PWM_W{1'b0}};
            end else begin
              pwm_cnt <= pwm_cnt + 8'h01;
            end
            pwm_q <= (pwm_cnt < pwm_duty);
          end
        end
        default: begin
          pwm_state <= ST_IDLE;
        end
      endcase
    end
  end

  // register writes and sticky status
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `CTRL_RST;
      dir <= 3'h0;
      pull <= 3'h0;
      outv <= 3'h0;
      mask <= 4'h0;
      stat <= 4'h0;
      pwm_duty <= `PWM_DUTY_RST;
      in_prev <= 3'h0;
    end else begin
      in_prev <= in_s;
      if (wr && addr == `REG_CTRL) begin
        ctrl <= wdata;
      end
      if (wr && addr == `REG_DIR) begin
        dir <= wdata[2:0];
      end
      if (wr && addr == `REG_PULL) begin
        pull <= wdata[2:0];
      end
      if (wr && addr == `REG_OUT) begin
        outv <= wdata[2:0];
      end
      if (wr && addr == `REG_MASK) begin
        mask <= wdata[3:0];
      end
      if (wr && addr == `REG_ALT) begin
        pwm_duty <= wdata;
      end
      // set wins over clear
      stat <= (stat & ~((wr && addr == `REG_STAT) ? wdata[3:0] : 4'h0)) | {alt_conflict, edge_ev};
    end
  end

  // read data one cycle after the strobe
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= {`DATA_W{1'b0}};
    end else if (rd) begin
      case (addr)
        `REG_CTRL: rdata <= ctrl;
        `REG_DIR: rdata <= {5'h00, dir};
        `REG_PULL: rdata <= {5'h00, pull};
        `REG_OUT: rdata <= {5'h00, outv};
        `REG_IN: rdata <= {2'h0, gp_ok, in_s};
        `REG_STAT: rdata <= {4'h0, stat};
        `REG_MASK: rdata <= {4'h0, mask};
        `REG_ALT: rdata <= pwm_duty;
        default: rdata <= {`DATA_W{1'b0}};
      endcase
    end else begin
      rdata <= {`DATA_W{1'b0}};
    end
  end
endmodule
`default_nettype wire

/* File: verification/display_host_model.sv */
// board side of the pins: display sync source, pull-ups and host levels
`timescale 1ns/10ps
`default_nettype none
module display_host_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [2:0] ext,
  input wire logic [2:0] drv,
  input wire logic [2:0] drv_oe,
  input wire logic [2:0] pull,
  output logic [2:0] pin
);
  logic [3:0] cnt;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      cnt <= 4'h0;
    else
      cnt <= cnt + 4'h1;
  end
  // pin zero sees a four cycle sync pulse every sixteen cycles
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin[i] = drv_oe[i] ? drv[i] : (pull[i] | (i == 0 ? &cnt[3:2] : ext[i]));
    end
  end
endmodule
`default_nettype wire

/* File: verification/pin_mux_assertions.sv */
// concurrent checks on the pin function mux ports
`timescale 1ns/10ps
`default_nettype none
module pin_mux_assertions (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [2:0] general_pin_oe,
  input wire logic [2:0] general_pin_pullup,
  input wire logic debug_active,
  input wire logic debug_data_oe,
  input wire logic frame_sync,
  input wire logic line_sync,
  input wire logic response_ready,
  input wire logic message_pending,
  input wire logic host_attention_line_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_attention_pull: assert property (host_attention_line_oe == (response_ready | message_pending))
    else $error("attention line does not follow pending work");
  a_reset_inputs: assert property ($rose(rst_b) |-> general_pin_oe == 3'h0)
    else $error("general pin driven right after reset");
  a_pull_input: assert property ((general_pin_pullup & general_pin_oe) == 3'h0)
    else $error("pull-up on a driven pin");
  a_debug_clock: assert property (debug_active |-> !general_pin_oe[1])
    else $error("pin one driven while debug clock owns it");
  a_debug_data: assert property (debug_active |-> general_pin_oe[2] == debug_data_oe)
    else $error("pin two drive not from debug core");
  a_debug_pull: assert property (debug_active |-> general_pin_pullup[2:1] == 2'h0)
    else $error("pull-up on a debug owned pin");
  a_sync_single: assert property (!(frame_sync && line_sync))
    else $error("frame and line sync both active");
  a_read_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read answer cycle");
endmodule
bind touch_ctrl_pin_function_mux pin_mux_assertions chk_i (.clk_sys(clk_sys), .rst_b(rst_b), .rd(rd),
  .rdata(rdata), .general_pin_oe(general_pin_oe), .general_pin_pullup(general_pin_pullup),
  .debug_active(debug_active), .debug_data_oe(debug_data_oe), .frame_sync(frame_sync),
  .line_sync(line_sync), .response_ready(response_ready), .message_pending(message_pending),
  .host_attention_line_oe(host_attention_line_oe));
`default_nettype wire

/* File: verification/touch_ctrl_pin_function_mux_test.sv */
// self-checking bench for the pin function mux
`timescale 1ns/10ps
`default_nettype none
`include "pin_mux_defs.vh"
module touch_ctrl_pin_function_mux_test;
  logic clk_sys = 0, rst_b = 0, wr = 0, rd = 0, dbg = 0, dbg_o = 0, dbg_oe = 0, resp = 0, msg = 0;
  logic [3:0] addr = 0;
  logic [7:0] wdata = 0, rdata, n;
  logic [2:0] ext = 0, pin, g_out, g_oe, g_pu;
  logic frame_sync, line_sync, attn_oe, irq;
  logic [31:0] seed = 32'hE669;
  int fails = 0, checked = 0, cyc = 0;
  touch_ctrl_pin_function_mux uut (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .general_pin_in(pin), .general_pin_out(g_out), .general_pin_oe(g_oe),
    .general_pin_pullup(g_pu), .debug_active(dbg), .debug_clock_line(), .debug_data_out(dbg_o),
    .debug_data_oe(dbg_oe), .debug_data_line(), .frame_sync(frame_sync), .line_sync(line_sync),
    .response_ready(resp), .message_pending(msg), .host_attention_line_out(),
    .host_attention_line_oe(attn_oe), .irq(irq));
  display_host_model far (.clk_sys(clk_sys), .rst_b(rst_b), .ext(ext), .drv(g_out), .drv_oe(g_oe),
    .pull(g_pu), .pin(pin));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic see_sync(input logic [7:0] exp);
    logic sf, sl;
    sf = 0;
    sl = 0;
    repeat (2) @(posedge clk_sys);
    repeat (40) begin
      @(posedge clk_sys);
      sf |= frame_sync;
      sl |= line_sync;
    end
    chk(8'({sf, sl}), exp);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1 chk(8'(g_oe), 8'h00);
    rreg(`REG_DIR, `DIR_RST);
    rreg(4'hF, 8'h00);
    wreg(`REG_CTRL, 8'h01);
    repeat (6) begin
      seed = lfsr(seed);
      resp <= seed[3];
      msg <= seed[4];
      ext <= seed[7:5];
      wreg(`REG_DIR, 8'(seed[2:0]));
      chk(8'(g_oe), 8'(seed[2:0]));
      chk(8'(attn_oe), 8'(resp | msg));
      rreg(`REG_DIR, 8'(seed[2:0]));
    end
    wreg(`REG_DIR, 8'h07);
    wreg(`REG_OUT, 8'h00);
    chk(8'({g_oe, g_out}), 8'h38);
    wreg(`REG_DIR, 8'h00);
    wreg(`REG_PULL, 8'h07);
    chk(8'(g_pu), 8'h07);
    repeat (6) @(posedge clk_sys);
    rreg(`REG_IN, 8'h3F);
    wreg(`REG_PULL, 8'h00);
    wreg(`REG_DIR, 8'h07);
    wreg(`REG_CTRL, 8'h03);
    chk(8'(g_oe), 8'h06);
    see_sync(8'h02);
    wreg(`REG_CTRL, 8'h06);
    chk(8'(g_oe), 8'h00);
    see_sync(8'h01);
    seed = lfsr(seed);
    wreg(`REG_ALT, seed[7:0]);
    wreg(`REG_CTRL, 8'h09);
    chk(8'(g_oe), 8'h07);
    n = 0;
    repeat (4) @(posedge clk_sys);
    repeat (256) begin
      @(posedge clk_sys);
      #1 n += 8'(g_out[1]);
    end
    chk(n, seed[7:0]);
    dbg_oe <= 1'b1;
    dbg_o <= 1'b1;
    dbg <= 1'b1;
    wreg(`REG_MASK, 8'h00);
    chk(8'({g_oe, g_out[2], irq}), 8'h16);
    wreg(`REG_MASK, 8'h08);
    chk(8'(irq), 8'h01);
    dbg <= 1'b0;
    wreg(`REG_STAT, 8'hFF);
    chk(8'(irq), 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
